// ### pkg/crb_pkg.sv
// Package: constants and carrier types for the reset, interrupt and bus control block.
`default_nettype none

package crb_pkg;

	// =====================================================================
	// Vector and fixed addresses
	localparam logic [15:0] VEC_RESET_LO   = 16'hFFFC;
	localparam logic [15:0] VEC_RESET_HI   = 16'hFFFD;
	localparam logic [15:0] VEC_IRQ_LO     = 16'hFFFE;
	localparam logic [15:0] VEC_IRQ_HI     = 16'hFFFF;
	localparam logic [7:0]  STACK_PAGE     = 8'h01;
	localparam logic [15:0] BANK_EXEC_ADDR = 16'h0000;
	localparam logic [15:0] BANK_IND_ADDR  = 16'h0001;
	localparam int          BANK_BITS      = 4;
	localparam logic [3:0]  BANK_RESET     = 4'hF;

	// =====================================================================
	// Timing
	localparam int          CLK_PERIOD_NS   = 100;
	localparam logic [2:0]  INIT_CYCLES     = 3'h6;
	localparam logic [1:0]  RST_LOW_MIN     = 2'h2;
	localparam int          RDY_WINDOW_NS   = 100;
	localparam int          RDY_WINDOW_CLKS = (RDY_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(RDY_WINDOW_NS / CLK_PERIOD_NS);
	// One bus cycle is four clocks: two of phase one, two of phase two.
	localparam logic [1:0]  CNT_LAST        = 2'h3;
	localparam logic [1:0]  PH2_START       = 2'h2;
	localparam logic [1:0]  READY_SAMPLE    = 2'(int'(PH2_START) + RDY_WINDOW_CLKS - 1);
	// Synchroniser reset: reset pin low, interrupt high, ready high, enable low, data zero.
	localparam logic [11:0] SYNC_RESET      = 12'h600;

	// =====================================================================
	// Types
	typedef enum logic [3:0] {
		ST_HOLD, ST_INIT, ST_RVEC_LO, ST_RVEC_HI, ST_RUN,
		ST_PUSH_PCH, ST_PUSH_PCL, ST_PUSH_P, ST_IVEC_LO, ST_IVEC_HI
	} crb_state_t;

	typedef struct packed {
		logic        active;
		logic        we;
		logic        ind;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} crb_cyc_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        addr_oe;
		logic [7:0]  data;
		logic        data_oe;
		logic        rw;
		logic        rw_oe;
	} crb_bus_t;

	typedef struct packed {
		logic [3:0] exec_bank;
		logic [3:0] ind_bank;
	} crb_bank_st_t;

	typedef struct packed {
		crb_state_t  st;
		logic [1:0]  cnt;
		logic [2:0]  init_n;
		logic [1:0]  low_n;
		logic        rw_valid;
		logic        rst_prev;
		logic        i_flag;
		logic        irq_pend;
		logic        rdy_low;
		logic        halted;
		logic        ack;
		logic        pc_load;
		logic        irq_taken;
		crb_cyc_t    cyc;
		logic [7:0]  rdata;
		logic [15:0] pc;
		logic [7:0]  sp;
		logic [7:0]  stat;
	} crb_ctl_st_t;

endpackage : crb_pkg

`default_nettype wire

// ### hw/crb_sync.sv
// Two-stage synchroniser for pin inputs.
`default_nettype none

module crb_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// Pins in, synchronised out
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	// =====================================================================
	// State: stage 0 is read only by stage 1.
	logic [1:0][WIDTH-1:0] q;
	logic [1:0][WIDTH-1:0] d;

	always_comb begin
		d[0] = din;
		d[1] = q[0];
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= {RESET_VAL, RESET_VAL};
		end else begin
			q <= d;
		end
	end

	assign dout = q[1];

endmodule : crb_sync

`default_nettype wire

// ### hw/crb_bank.sv
// Bank register pair that extends the address space by four bits.
`default_nettype none

module crb_bank (
	// Clock and reset
	input  wire logic                            clk_sys,
	input  wire logic                            reset,
	input  wire logic                            reset_input_s,
	// Register write port
	input  wire logic                            wr_en,
	input  wire logic                            wr_sel_ind,
	input  wire logic [crb_pkg::BANK_BITS-1:0]   wr_data,
	// Bank selection
	input  wire logic                            use_ind,
	output logic      [crb_pkg::BANK_BITS-1:0]   bank_select_outputs,
	output logic      [crb_pkg::BANK_BITS-1:0]   exec_val,
	output logic      [crb_pkg::BANK_BITS-1:0]   ind_val
);

	crb_pkg::crb_bank_st_t q;
	crb_pkg::crb_bank_st_t d;

	always_comb begin
		d = q;
		if (!reset_input_s) begin
			d = '{exec_bank: crb_pkg::BANK_RESET, ind_bank: crb_pkg::BANK_RESET};
		end else if (wr_en) begin
			if (wr_sel_ind) begin
				d.ind_bank = wr_data;
			end else begin
				d.exec_bank = wr_data;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '{exec_bank: crb_pkg::BANK_RESET, ind_bank: crb_pkg::BANK_RESET};
		end else begin
			q <= d;
		end
	end

	// These pins stay driven whatever the bus enable does. [RULE_21]
	assign bank_select_outputs = use_ind ? q.ind_bank : q.exec_bank; // [RULE_20]
	assign exec_val            = q.exec_bank;
	assign ind_val             = q.ind_bank;

endmodule : crb_bank

`default_nettype wire

// ### hw/crb_ctrl.sv
// Reset, interrupt and bus control of an 8-bit processor with a banked address space.
`default_nettype none

// What this block does
// RULE_01: No read or write transfer while the reset pin is low.
// RULE_02: Rising reset pin starts the reset sequence at once.
// RULE_03: Six idle cycles, then set mask and fetch vector FFFC/FFFD.
// RULE_04: System holds reset low two cycles after power is good.
// RULE_05: After two low cycles the direction output becomes valid.
// RULE_06: Interrupt waits for the current instruction to finish.
// RULE_07: Interrupt taken at completion only if the mask flag is clear.
// RULE_08: Interrupt entry pushes program counter and status on the stack.
// RULE_09: Mask flag set after state is saved.
// RULE_10: Program counter then loaded from FFFE low and FFFF high.
// RULE_11: Address, data and direction driven only while bus enable is high.
// RULE_12: Bus enable low puts the address drivers in high impedance.
// RULE_13: Direction output high except during write cycles.
// RULE_14: Ready low in the sample window halts with the address held.
// RULE_15: Halt persists each cycle ready stays low; resumes when high.
// RULE_16: Ready low in a write cycle waits for the next read.
// RULE_17: System supplies two non-overlapping clock phases.
// RULE_18: Eight-bit two-way data bus with tri-state drivers.
// RULE_19: Sixteen-bit tri-state address bus for shared memory.
// RULE_20: Four bank bits from a register extend reach to one megabyte.
// RULE_21: Bank outputs are never tri-stated nor gated by bus enable.
// RULE_22: Reset vector low byte from lower address, high byte from next.
module crb_ctrl (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	// Pins
	input  wire logic                 reset_input_n,
	input  wire logic                 irq_n,
	input  wire logic                 ready,
	input  wire logic                 bus_output_enable,
	input  wire logic [7:0]           data_in,
	output crb_pkg::crb_bus_t         bus,
	output logic      [3:0]           bank_select_outputs,
	// Core bus requests
	input  wire crb_pkg::crb_cyc_t    core_req,
	output logic                      core_ready,
	output logic                      core_ack,
	output logic      [7:0]           core_rdata,
	// Core execution state
	input  wire logic                 core_instr_done,
	input  wire logic [15:0]          core_pc,
	input  wire logic [7:0]           core_sp,
	input  wire logic [7:0]           core_status,
	input  wire logic                 core_mask_set,
	input  wire logic                 core_mask_clr,
	// Sequence results
	output logic                      pc_load,
	output logic      [15:0]          pc_value,
	output logic                      irq_taken,
	output logic                      int_mask,
	output logic                      phase_two,
	output logic                      halted
);

	// =====================================================================
	// Helpers
	function automatic crb_pkg::crb_cyc_t mk_cyc(input logic [15:0] addr, input logic we,
		input logic [7:0] wdata);
		mk_cyc = '{active: 1'b1, we: we, ind: 1'b0, addr: addr, wdata: wdata};
	endfunction : mk_cyc

	function automatic logic [15:0] stack_addr(input logic [7:0] sp, input logic [1:0] off);
		stack_addr = {crb_pkg::STACK_PAGE, sp - {6'h00, off}};
	endfunction : stack_addr

	function automatic logic is_bank(input logic [15:0] addr);
		is_bank = (addr == crb_pkg::BANK_EXEC_ADDR) || (addr == crb_pkg::BANK_IND_ADDR);
	endfunction : is_bank

	localparam crb_pkg::crb_cyc_t    CYC_IDLE  = '0;
	localparam crb_pkg::crb_ctl_st_t CTL_RESET = '{st: crb_pkg::ST_HOLD, default: '0};

	// =====================================================================
	// Pin synchronisation
	logic [11:0] sync_w;
	logic        rst_s;
	logic        irq_s_n;
	logic        ready_s;
	logic        aec_s;
	logic [7:0]  data_s;

	crb_sync #(
		.WIDTH     (12),
		.RESET_VAL (crb_pkg::SYNC_RESET)
	) u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.din     ({reset_input_n, irq_n, ready, bus_output_enable, data_in}),
		.dout    (sync_w)
	);

	assign rst_s   = sync_w[11];
	assign irq_s_n = sync_w[10];
	assign ready_s = sync_w[9];
	assign aec_s   = sync_w[8];
	assign data_s  = sync_w[7:0];

	// =====================================================================
	// Bank registers
	crb_pkg::crb_ctl_st_t q;
	crb_pkg::crb_ctl_st_t d;
	logic       bank_wr;
	logic [3:0] exec_val;
	logic [3:0] ind_val;

	assign bank_wr = rst_s && q.rst_prev && (q.cnt == crb_pkg::CNT_LAST) && q.cyc.active
		&& q.cyc.we && (q.st == crb_pkg::ST_RUN) && is_bank(q.cyc.addr);

	crb_bank u_bank (
		.clk_sys             (clk_sys),
		.reset               (reset),
		.reset_input_s       (rst_s),
		.wr_en               (bank_wr),
		.wr_sel_ind          (q.cyc.addr[0]),
		.wr_data             (q.cyc.wdata[3:0]),
		.use_ind             (q.cyc.active && q.cyc.ind),
		.bank_select_outputs (bank_select_outputs),
		.exec_val            (exec_val),
		.ind_val             (ind_val)
	);

	// =====================================================================
	// Sequencer
	logic       cyc_end;
	logic       stall;
	logic       req_take;
	logic [7:0] rd_byte;

	assign cyc_end = q.cnt == crb_pkg::CNT_LAST;
	// A read in which ready was seen low repeats; writes never stall. [RULE_14] [RULE_16]
	assign stall   = q.cyc.active && !q.cyc.we && q.rdy_low;
	assign core_ready = rst_s && q.rst_prev && (q.st == crb_pkg::ST_RUN) && cyc_end && !stall
		&& !q.irq_pend;
	assign req_take = core_ready && core_req.active;
	// Bank registers read back with the upper four data bits as zero.
	assign rd_byte = is_bank(q.cyc.addr) ? {4'h0, q.cyc.addr[0] ? ind_val : exec_val} : data_s;

	always_comb begin
		d           = q;
		d.ack       = 1'b0;
		d.pc_load   = 1'b0;
		d.irq_taken = 1'b0;
		d.cnt       = q.cnt + 2'h1;
		d.rst_prev  = rst_s;
		if (q.cnt == crb_pkg::READY_SAMPLE) begin
			d.rdy_low = !ready_s; // [RULE_14] [RULE_15]
		end
		if (core_mask_clr) begin
			d.i_flag = 1'b0;
		end
		if (core_mask_set) begin
			d.i_flag = 1'b1;
		end
		// The request is looked at only when an instruction completes. [RULE_06] [RULE_07]
		if ((q.st == crb_pkg::ST_RUN) && core_instr_done && !irq_s_n && !q.i_flag) begin
			d.irq_pend = 1'b1;
		end
		if (!rst_s) begin
			d.st       = crb_pkg::ST_HOLD;
			d.cyc      = CYC_IDLE; // [RULE_01]
			d.halted   = 1'b0;
			d.irq_pend = 1'b0;
			if (q.low_n != crb_pkg::RST_LOW_MIN) begin
				d.low_n = q.low_n + 2'h1;
			end else begin
				d.rw_valid = 1'b1; // [RULE_05]
			end
		end else if (!q.rst_prev) begin
			// Restart the cycle count so the sequence begins on this edge. [RULE_02]
			d.st     = crb_pkg::ST_INIT;
			d.init_n = 3'h0;
			d.cnt    = 2'h0;
		end else if (cyc_end) begin
			if (stall) begin
				d.halted = 1'b1; // [RULE_15]
			end else begin
				d.halted = 1'b0;
				d.cyc    = CYC_IDLE;
				case (q.st)
					crb_pkg::ST_INIT: begin
						if (q.init_n == crb_pkg::INIT_CYCLES - 3'h1) begin
							d.i_flag = 1'b1; // [RULE_03]
							d.st     = crb_pkg::ST_RVEC_LO;
							d.cyc    = mk_cyc(crb_pkg::VEC_RESET_LO, 1'b0, 8'h00);
						end else begin
							d.init_n = q.init_n + 3'h1;
						end
					end
					crb_pkg::ST_RVEC_LO: begin
						d.pc[7:0] = rd_byte; // [RULE_22]
						d.st      = crb_pkg::ST_RVEC_HI;
						d.cyc     = mk_cyc(crb_pkg::VEC_RESET_HI, 1'b0, 8'h00);
					end
					crb_pkg::ST_RVEC_HI: begin
						d.pc[15:8] = rd_byte; // [RULE_03] [RULE_22]
						d.pc_load  = 1'b1;
						d.st       = crb_pkg::ST_RUN;
					end
					crb_pkg::ST_RUN: begin
						if (q.cyc.active) begin
							d.ack   = 1'b1;
							d.rdata = rd_byte; // [RULE_18]
						end
						if (q.irq_pend) begin
							d.irq_pend = 1'b0;
							d.pc       = core_pc;
							d.sp       = core_sp;
							d.stat     = core_status;
							d.st       = crb_pkg::ST_PUSH_PCH;
							d.cyc      = mk_cyc(stack_addr(core_sp, 2'h0), 1'b1, core_pc[15:8]); // [RULE_08]
						end else if (req_take) begin
							d.cyc = core_req;
						end
					end
					crb_pkg::ST_PUSH_PCH: begin
						d.st  = crb_pkg::ST_PUSH_PCL;
						d.cyc = mk_cyc(stack_addr(q.sp, 2'h1), 1'b1, q.pc[7:0]); // [RULE_08]
					end
					crb_pkg::ST_PUSH_PCL: begin
						d.st  = crb_pkg::ST_PUSH_P;
						d.cyc = mk_cyc(stack_addr(q.sp, 2'h2), 1'b1, q.stat); // [RULE_08]
					end
					crb_pkg::ST_PUSH_P: begin
						d.i_flag = 1'b1; // [RULE_09]
						d.st     = crb_pkg::ST_IVEC_LO;
						d.cyc    = mk_cyc(crb_pkg::VEC_IRQ_LO, 1'b0, 8'h00); // [RULE_10]
					end
					crb_pkg::ST_IVEC_LO: begin
						d.pc[7:0] = rd_byte;
						d.st      = crb_pkg::ST_IVEC_HI;
						d.cyc     = mk_cyc(crb_pkg::VEC_IRQ_HI, 1'b0, 8'h00); // [RULE_10]
					end
					crb_pkg::ST_IVEC_HI: begin
						d.pc[15:8]  = rd_byte; // [RULE_10]
						d.pc_load   = 1'b1;
						d.irq_taken = 1'b1;
						d.st        = crb_pkg::ST_RUN;
					end
					default: begin
						d.st = crb_pkg::ST_HOLD;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= CTL_RESET;
		end else begin
			q <= d;
		end
	end

	// =====================================================================
	// Pin drivers
	always_comb begin
		bus.addr    = q.cyc.addr; // [RULE_14]
		bus.addr_oe = aec_s; // [RULE_12] [RULE_19]
		bus.data    = q.cyc.wdata;
		bus.data_oe = aec_s && rst_s && q.cyc.active && q.cyc.we && (q.cnt >= crb_pkg::PH2_START); // [RULE_11]
		bus.rw      = !(rst_s && q.cyc.active && q.cyc.we); // [RULE_13] [RULE_01]
		bus.rw_oe   = aec_s && q.rw_valid; // [RULE_11] [RULE_05]
	end

	assign core_ack   = q.ack;
	assign core_rdata = q.rdata;
	assign pc_load    = q.pc_load;
	assign pc_value   = q.pc;
	assign irq_taken  = q.irq_taken;
	assign int_mask   = q.i_flag;
	// Phases are derived from the cycle count; the two never overlap. [RULE_17]
	assign phase_two  = q.cnt >= crb_pkg::PH2_START;
	assign halted     = q.halted;

	// =====================================================================
	// Assertions
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	property p_no_xfer_in_reset;
		!rst_s |-> (!bus.data_oe && bus.rw);
	endproperty
	a_no_xfer_in_reset: assert property (p_no_xfer_in_reset) else $error("transfer while reset held"); // [RULE_01]

	property p_reset_start;
		(rst_s && !q.rst_prev) |=> (q.st == crb_pkg::ST_INIT) && (q.cnt == 2'h0);
	endproperty
	a_reset_start: assert property (p_reset_start) else $error("reset sequence did not start"); // [RULE_02]

	property p_reset_vec;
		(q.st == crb_pkg::ST_RVEC_LO) |-> (q.cyc.addr == crb_pkg::VEC_RESET_LO) && q.cyc.active
			&& !q.cyc.we && (q.init_n == crb_pkg::INIT_CYCLES - 3'h1);
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset vector fetch wrong"); // [RULE_03]

	property p_rw_valid;
		(!rst_s) [*4] |-> q.rw_valid;
	endproperty
	a_rw_valid: assert property (p_rw_valid) else $error("direction not valid after reset low"); // [RULE_05]

	property p_irq_at_done;
		$rose(q.irq_pend) |-> $past(core_instr_done) && !$past(irq_s_n);
	endproperty
	a_irq_at_done: assert property (p_irq_at_done) else $error("interrupt taken mid instruction"); // [RULE_06]

	property p_mask_blocks;
		$rose(q.irq_pend) |-> !$past(q.i_flag);
	endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("masked interrupt accepted"); // [RULE_07]

	property p_push_write;
		(q.st inside {crb_pkg::ST_PUSH_PCH, crb_pkg::ST_PUSH_PCL, crb_pkg::ST_PUSH_P}) |->
			q.cyc.we && (q.cyc.addr[15:8] == crb_pkg::STACK_PAGE);
	endproperty
	a_push_write: assert property (p_push_write) else $error("push cycle not a stack write"); // [RULE_08]

	property p_mask_after_push;
		(q.st == crb_pkg::ST_PUSH_P) ##1 (q.st == crb_pkg::ST_IVEC_LO) |-> q.i_flag;
	endproperty
	a_mask_after_push: assert property (p_mask_after_push) else $error("mask not set after push"); // [RULE_09]

	property p_irq_vec;
		(q.st == crb_pkg::ST_IVEC_LO) && cyc_end && !stall && rst_s && q.rst_prev |=>
			(q.st == crb_pkg::ST_IVEC_HI) && (q.cyc.addr == crb_pkg::VEC_IRQ_HI);
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector order wrong"); // [RULE_10]

	property p_bus_release;
		!aec_s |-> !bus.addr_oe && !bus.data_oe && !bus.rw_oe;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("bus driven while released"); // [RULE_11] [RULE_12]

	property p_rw_high;
		!q.cyc.we |-> bus.rw;
	endproperty
	a_rw_high: assert property (p_rw_high) else $error("direction low outside write"); // [RULE_13]

	property p_halt_holds;
		(stall && cyc_end && rst_s && q.rst_prev) |=> $stable(bus.addr) ##3 halted;
	endproperty
	a_halt_holds: assert property (p_halt_holds) else $error("halt did not hold address"); // [RULE_14] [RULE_15]

	property p_write_no_halt;
		(q.cyc.active && q.cyc.we && cyc_end && rst_s && q.rst_prev) |=> !q.halted;
	endproperty
	a_write_no_halt: assert property (p_write_no_halt) else $error("write cycle halted"); // [RULE_16]

	property p_reset_vec_order;
		(q.st == crb_pkg::ST_RVEC_LO) && cyc_end && rst_s && q.rst_prev && !stall |=>
			(q.cyc.addr == crb_pkg::VEC_RESET_HI) && (q.pc[7:0] == $past(rd_byte));
	endproperty
	a_reset_vec_order: assert property (p_reset_vec_order) else $error("reset vector byte order wrong"); // [RULE_22]

	c_reset_load: cover property (q.pc_load && !q.irq_taken);
	c_irq_taken:  cover property (q.irq_taken);
	c_halt:       cover property (q.halted ##4 !q.halted);
	c_bank_write: cover property (bank_wr);

endmodule : crb_ctrl

`default_nettype wire

// ### verif/crb_mem_model.sv
// Memory and peripheral model that answers the control block on its bus pins.
`default_nettype none

module crb_mem_model #(
	parameter logic [15:0] RST_VEC = 16'h1234,
	parameter logic [15:0] IRQ_VEC = 16'h5678
) (
	// Clock
	input  wire logic              clk_sys,
	// Bus pins
	input  wire crb_pkg::crb_bus_t bus,
	output logic      [7:0]        data_in,
	output logic                   ready,
	// Stall control from the bench
	input  wire logic              slow
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0]  mem [0:65535];
	logic [7:0]  last_q;
	logic [15:0] prev_q;
	int          wait_q;

	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 7 + 3);
		mem[16'hFFFC] = RST_VEC[7:0];
		mem[16'hFFFD] = RST_VEC[15:8];
		mem[16'hFFFE] = IRQ_VEC[7:0];
		mem[16'hFFFF] = IRQ_VEC[15:8];
		last_q = 8'h00;
		prev_q = 16'h0000;
		wait_q = 0;
	end

	// The line is not pulled, so an undriven bus shows the inverse of the last byte.
	assign data_in = (bus.addr_oe && bus.rw) ? mem[bus.addr] : ~last_q;
	assign ready = (wait_q == 0);

	// ==================================================================
	// Slow mode stalls every new address, writes included, to probe the ignore rule.
	always @(posedge clk_sys) begin
		if (bus.addr_oe && bus.rw) last_q <= data_in;
		prev_q <= bus.addr;
		if (slow && bus.addr != prev_q) wait_q <= 6;
		else if (wait_q > 0) wait_q <= wait_q - 1;
		if (bus.addr_oe && bus.data_oe && !bus.rw) mem[bus.addr] <= bus.data;
	end

endmodule : crb_mem_model

`default_nettype wire

// ### verif/crb_ctrl_tb_top.sv
// Self-checking testbench for the reset, interrupt and bus control block.
`default_nettype none

module crb_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [15:0] RST_VEC = 16'h1234;
	localparam logic [15:0] IRQ_VEC = 16'h5678;

	logic              clk_sys, reset, reset_input_n, irq_n, ready, bus_output_enable, slow;
	logic [7:0]        data_in, core_rdata, core_sp, core_status;
	crb_pkg::crb_bus_t bus;
	crb_pkg::crb_cyc_t core_req;
	logic [3:0]        bank_select_outputs, bank;
	logic              core_ready, core_ack, core_instr_done, core_mask_set, core_mask_clr;
	logic [15:0]       core_pc, pc_value, addr_prev, a;
	logic              pc_load, irq_taken, int_mask, phase_two, halted;
	logic [8:0]        rd_q [$];
	logic [16:0]       pc_q [$];
	logic [8:0]        rd_note;
	logic [16:0]       pc_note;
	logic [7:0]        d;
	int                num_errors, checks_done, halt_seen, seed;

	crb_ctrl dut (.clk_sys(clk_sys), .reset(reset), .reset_input_n(reset_input_n), .irq_n(irq_n),
		.ready(ready), .bus_output_enable(bus_output_enable), .data_in(data_in), .bus(bus),
		.bank_select_outputs(bank_select_outputs), .core_req(core_req), .core_ready(core_ready),
		.core_ack(core_ack), .core_rdata(core_rdata), .core_instr_done(core_instr_done),
		.core_pc(core_pc), .core_sp(core_sp), .core_status(core_status), .core_mask_set(core_mask_set),
		.core_mask_clr(core_mask_clr), .pc_load(pc_load), .pc_value(pc_value), .irq_taken(irq_taken),
		.int_mask(int_mask), .phase_two(phase_two), .halted(halted));

	crb_mem_model #(.RST_VEC(RST_VEC), .IRQ_VEC(IRQ_VEC)) u_far (.clk_sys(clk_sys), .bus(bus),
		.data_in(data_in), .ready(ready), .slow(slow));

	always #50 clk_sys = ~clk_sys;

	// ==================================================================
	// Shared tasks
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("Counts: checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	// Request is held until a settled core_ready is seen, then taken at the next edge.
	task automatic op(input logic we, input logic [15:0] adr, input logic [7:0] wd, input logic [7:0] exp);
		int n;
		n = 0;
		core_req = '{active: 1'b1, we: we, ind: 1'b0, addr: adr, wdata: wd};
		@(negedge clk_sys);
		while (core_ready !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 400) chk(17'h0_0001, 17'h0_0000);
		rd_q.push_back({!we, exp});
		tick();
	endtask : op

	task automatic drain(input int limit, input int extra);
		int n;
		n = 0;
		core_req.active = 1'b0;
		while ((rd_q.size() + pc_q.size()) != 0 && n < limit) begin
			tick();
			n++;
		end
		if (n >= limit) chk(17'h0_0001, 17'h0_0000);
		repeat (extra) tick();
	endtask : drain

	// ==================================================================
	// Monitor: takes the oldest note whenever a result appears.
	always @(negedge clk_sys) begin
		if (core_ack === 1'b1) begin
			if (rd_q.size() == 0) chk(17'h0_0001, 17'h0_0000);
			else begin
				rd_note = rd_q.pop_front();
				if (rd_note[8]) chk({9'h000, core_rdata}, {9'h000, rd_note[7:0]});
			end
		end
		if (pc_load === 1'b1) begin
			if (pc_q.size() == 0) chk(17'h0_0001, 17'h0_0000);
			else begin
				pc_note = pc_q.pop_front();
				chk({irq_taken, pc_value}, pc_note);
			end
		end
		if (halted === 1'b1) begin
			halt_seen++;
			chk({1'b0, bus.addr}, {1'b0, addr_prev});
			chk({16'h0000, bus.rw}, 17'h0_0001);
		end
		// A cycle ends in phase two and the next opens in phase one.
		if (core_ack === 1'b1 || core_ready === 1'b1) begin
			chk({16'h0000, phase_two}, {16'h0000, core_ready});
		end
		addr_prev = bus.addr;
	end

	initial begin
		#4_000_000;
		num_errors++;
		end_sim();
	end

	// ==================================================================
	// Main sequence
	initial begin
		{clk_sys, irq_n, bus_output_enable} = 3'b011;
		{reset, reset_input_n, slow, core_instr_done, core_mask_set, core_mask_clr} = 6'b100000;
		{core_req, core_pc, core_sp, core_status} = '0;
		{num_errors, checks_done, halt_seen} = '0;
		seed = 52;
		repeat (12) tick();
		reset = 1'b0;
		repeat (4) tick();
		chk({14'h0000, bus.data_oe, bus.rw, bus.rw_oe}, 17'h0_0003);
		chk({13'h0000, bank_select_outputs}, 17'h0_000F);
		pc_q.push_back({1'b0, RST_VEC});
		reset_input_n = 1'b1;
		drain(42, 2);
		chk({16'h0000, int_mask}, 17'h0_0001);
		$display("Test reset done");

		for (int i = 0; i < 8; i++) begin
			slow = (i >= 4);
			a = 16'h0200 + 16'($random(seed) & 16'h0FFF);
			d = 8'($random(seed));
			op(1'b1, a, d, 8'h00);
			op(1'b0, a, 8'h00, d);
		end
		drain(800, 2);
		slow = 1'b0;
		chk({16'h0000, halt_seen != 0}, 17'h0_0001);
		$display("Test data transfers done");

		bank = 4'($random(seed));
		op(1'b1, 16'h0000, {4'h0, bank}, 8'h00);
		op(1'b0, 16'h0000, 8'h00, {4'h0, bank});
		drain(100, 2);
		chk({13'h0000, bank_select_outputs}, {13'h0000, bank});
		bus_output_enable = 1'b0;
		repeat (4) tick();
		chk({14'h0000, bus.addr_oe, bus.data_oe, bus.rw_oe}, 17'h0_0000);
		chk({13'h0000, bank_select_outputs}, {13'h0000, bank});
		bus_output_enable = 1'b1;
		repeat (4) tick();
		$display("Test bank and bus release done");

		reset_input_n = 1'b0;
		repeat (4) tick();
		chk({15'h0000, bus.data_oe, bus.rw}, 17'h0_0001);
		chk({13'h0000, bank_select_outputs}, 17'h0_000F);
		pc_q.push_back({1'b0, RST_VEC});
		reset_input_n = 1'b1;
		drain(42, 2);
		chk({16'h0000, int_mask}, 17'h0_0001);
		$display("Test second reset done");

		core_pc = 16'($random(seed));
		core_status = 8'($random(seed));
		core_sp = 8'hF0;
		{core_mask_set, core_mask_clr} = 2'b11;
		tick();
		chk({16'h0000, int_mask}, 17'h0_0001);
		{core_mask_set, core_mask_clr} = 2'b01;
		tick();
		core_mask_clr = 1'b0;
		irq_n = 1'b0;
		repeat (6) tick();
		chk({16'h0000, int_mask}, 17'h0_0000);
		pc_q.push_back({1'b1, IRQ_VEC});
		core_instr_done = 1'b1;
		tick();
		core_instr_done = 1'b0;
		drain(60, 2);
		chk({9'h000, u_far.mem[16'h01F0]}, {9'h000, core_pc[15:8]});
		chk({9'h000, u_far.mem[16'h01EF]}, {9'h000, core_pc[7:0]});
		chk({9'h000, u_far.mem[16'h01EE]}, {9'h000, core_status});
		chk({16'h0000, int_mask}, 17'h0_0001);
		core_instr_done = 1'b1;
		tick();
		core_instr_done = 1'b0;
		repeat (40) tick();
		irq_n = 1'b1;
		$display("Test interrupt done");
		end_sim();
	end

endmodule : crb_ctrl_tb_top

`default_nettype wire
